// ===== design/i2cs_control_port.v
// two-wire slave control port with sixteen byte-wide configuration registers
// assumes scl and sda come from the bus pins asynchronous to clk_sys, and
// address-select pins are static straps
`timescale 1ns/10ps
`include "i2cs_map.vh"

module i2cs_control_port (
   input wire clk_sys,
   input wire rst_b,
   input wire sclIn,
   input wire sdaIn,
   output reg sdaOut,
   output reg sdaOe,
   input wire addr_select_msb,
   input wire addr_select_mid,
   input wire addr_select_lsb,
   output reg [8*`I2CS_REG_COUNT-1:0] regFile
);

   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_WBYTE = 3'h3;
   localparam ST_WACK = 3'h4;
   localparam ST_RBYTE = 3'h5;
   localparam ST_RACK = 3'h6;

   // three-stage synchronisers; stage 1 only feeds stage 2
   reg [2:0] sclSync;
   reg [2:0] sdaSync;
   reg sclLvl;
   reg sdaLvl;
   reg [2:0] selSync1;
   reg [2:0] selSync2;
   reg [2:0] selSync3;
   reg [2:0] selLvl;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclSync <= 3'h7;
         sdaSync <= 3'h7;
         sclLvl <= 1'b1;
         sdaLvl <= 1'b1;
         selSync1 <= 3'h0;
         selSync2 <= 3'h0;
         selSync3 <= 3'h0;
         selLvl <= 3'h0;
      end else begin
         sclSync <= {sclSync[1:0], sclIn};
         sdaSync <= {sdaSync[1:0], sdaIn};
         // a change counts only once stages two and three agree (glitch filter)
         if (sclSync[1] == sclSync[2]) sclLvl <= sclSync[2];
         if (sdaSync[1] == sdaSync[2]) sdaLvl <= sdaSync[2];
         selSync1 <= {addr_select_msb, addr_select_mid, addr_select_lsb};
         selSync2 <= selSync1;
         selSync3 <= selSync2;
         // straps count once stages two and three agree, like the bus pins
         if (selSync2 == selSync3) selLvl <= selSync3;
      end
   end

   // filtered levels delayed one cycle for edge finding
   reg sclLvlD;
   reg sdaLvlD;
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclLvlD <= 1'b1;
         sdaLvlD <= 1'b1;
      end else begin
         sclLvlD <= sclLvl;
         sdaLvlD <= sdaLvl;
      end
   end

   wire sclRise = sclLvl & ~sclLvlD;
   wire sclFall = ~sclLvl & sclLvlD;
   wire startCond = sclLvl & sclLvlD & sdaLvlD & ~sdaLvl;
   wire stopCond = sclLvl & sclLvlD & ~sdaLvlD & sdaLvl;
   wire [6:0] ownAddr = {`I2CS_ADDR_FIXED, selLvl};

   reg [2:0] state_reg;
   reg [3:0] bitCnt_reg;
   reg [7:0] shift_reg;
   reg [7:0] index_reg;
   reg haveIndex_reg;
   reg nackSeen_reg;

   // register read mux; indices outside the map read as zero
   reg [7:0] rdData;
   integer k;
   always @* begin
      rdData = 8'h00;
      for (k = 0; k < `I2CS_REG_COUNT; k = k + 1) begin
         if (index_reg == `I2CS_REG_FIRST + k[7:0]) rdData = regFile[8*k +: 8];
      end
   end

   // protocol engine; bits sampled on scl rise, sda changed on scl fall
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         index_reg <= 8'h00;
         haveIndex_reg <= 1'b0;
         nackSeen_reg <= 1'b0;
         sdaOut <= 1'b1;
         sdaOe <= 1'b0;
      end else if (startCond) begin
         // repeated start also ends any write burst, keeps index for reads
         state_reg <= ST_ADDR;
         bitCnt_reg <= 4'h0;
         haveIndex_reg <= 1'b0;
         sdaOe <= 1'b0;
         sdaOut <= 1'b1;
      end else if (stopCond) begin
         state_reg <= ST_IDLE;
         sdaOe <= 1'b0;
         sdaOut <= 1'b1;
      end else begin
         case (state_reg)
            ST_ADDR, ST_WBYTE: begin
               if (sclRise) begin
                  shift_reg <= {shift_reg[6:0], sdaLvl};
                  bitCnt_reg <= bitCnt_reg + 4'h1;
               end else if (sclFall && bitCnt_reg == `I2CS_BITS_PER_BYTE) begin
                  bitCnt_reg <= 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (shift_reg[7:1] == ownAddr) begin
                        state_reg <= ST_AACK;
                        sdaOe <= 1'b1;
                        sdaOut <= 1'b0;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end else begin
                     // every written byte is acknowledged
                     state_reg <= ST_WACK;
                     sdaOe <= 1'b1;
                     sdaOut <= 1'b0;
                     if (!haveIndex_reg) begin
                        index_reg <= shift_reg;
                        haveIndex_reg <= 1'b1;
                     end else begin
                        index_reg <= index_reg + 8'h01;
                     end
                  end
               end
            end
            ST_AACK: begin
               if (sclFall) begin
                  if (shift_reg[0]) begin
                     // first read bit goes out during scl low
                     state_reg <= ST_RBYTE;
                     sdaOe <= ~rdData[7];
                     sdaOut <= 1'b0;
                     shift_reg <= {rdData[6:0], 1'b0};
                     bitCnt_reg <= 4'h1;
                  end else begin
                     state_reg <= ST_WBYTE;
                     sdaOe <= 1'b0;
                     sdaOut <= 1'b1;
                  end
               end
            end
            ST_WACK: begin
               if (sclFall) begin
                  state_reg <= ST_WBYTE;
                  sdaOe <= 1'b0;
                  sdaOut <= 1'b1;
               end
            end
            ST_RBYTE: begin
               if (sclFall) begin
                  if (bitCnt_reg == `I2CS_BITS_PER_BYTE) begin
                     // let the master drive the acknowledge
                     state_reg <= ST_RACK;
                     sdaOe <= 1'b0;
                     sdaOut <= 1'b1;
                     bitCnt_reg <= 4'h0;
                     index_reg <= index_reg + 8'h01;
                  end else begin
                     // open drain: drive only zeros, release for ones
                     sdaOe <= ~shift_reg[7];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (sclRise) nackSeen_reg <= sdaLvl;
               if (sclFall) begin
                  if (nackSeen_reg) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     state_reg <= ST_RBYTE;
                     sdaOe <= ~rdData[7];
                     sdaOut <= 1'b0;
                     shift_reg <= {rdData[6:0], 1'b0};
                     bitCnt_reg <= 4'h1;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               sdaOe <= 1'b0;
               sdaOut <= 1'b1;
            end
         endcase
      end
   end

   // register writes happen when the data byte is acknowledged
   wire wrStrobe = ~startCond & ~stopCond & (state_reg == ST_WBYTE) & sclFall &
      (bitCnt_reg == `I2CS_BITS_PER_BYTE) & haveIndex_reg;
   // the data byte lands at the current index, which then steps on
   wire [7:0] wrIndex = index_reg;
   genvar g;
   generate
      for (g = 0; g < `I2CS_REG_COUNT; g = g + 1) begin : gReg
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               regFile[8*g +: 8] <= `I2CS_REG_RESET;
            end else if (wrStrobe && wrIndex == `I2CS_REG_FIRST + g) begin
               regFile[8*g +: 8] <= shift_reg;
            end
         end
      end
   endgenerate

endmodule

// ===== design/i2cs_map.vh
// constants for the two-wire control slave port
// assumes inclusion by i2cs_control_port.v only
`ifndef I2CS_MAP_VH
`define I2CS_MAP_VH
`define I2CS_ADDR_FIXED 4'hd
`define I2CS_REG_FIRST 8'h01
`define I2CS_REG_LAST 8'h10
`define I2CS_REG_COUNT 16
`define I2CS_REG_RESET 8'h00
`define I2CS_BITS_PER_BYTE 4'h8
`endif

// ===== verification/i2cs_control_port_sva.sv
// port assertions for the two-wire control slave port
// assumes binding to i2cs_control_port, all sampled on clk_sys
`timescale 1ns/10ps
module i2cs_control_port_sva (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic addr_select_msb,
   input wire logic addr_select_mid,
   input wire logic addr_select_lsb,
   input wire logic [127:0] regFile
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // bus conditions seen on the raw pins
   sequence s_start;
      sclIn && $fell(sdaIn);
   endsequence
   sequence s_stop;
      sclIn && $rose(sdaIn);
   endsequence
   a_drive_low: assert property (sdaOe |-> !sdaOut)
      else $error("sda driven high");
   a_reset_state: assert property ($rose(rst_b) |-> !sdaOe && sdaOut && regFile == '0)
      else $error("state after reset");
   a_edge_change: assert property ($changed(sdaOe) |-> !$past(sclIn))
      else $error("sda changed with scl high");
   a_ack_hold: assert property ($rose(sdaOe) |-> sdaOe[*5])
      else $error("ack drive too short");
   a_release_bound: assert property ($rose(sdaOe) |-> ##[1:80] !sdaOe)
      else $error("sda never released");
   a_start_quiet: assert property (s_start |=> !sdaOe[*8])
      else $error("drive after start");
   a_stop_quiet: assert property (s_stop |=> !sdaOe[*4])
      else $error("drive after stop");
   a_reg_update: assert property ($changed(regFile) |-> !$past(sclIn) && !$past(sdaOe))
      else $error("register update off the data byte end");
endmodule
bind i2cs_control_port i2cs_control_port_sva u_sva (.clk_sys, .rst_b, .sclIn, .sdaIn,
   .sdaOut, .sdaOe, .addr_select_msb, .addr_select_mid, .addr_select_lsb, .regFile);

// ===== verification/i2cs_bus_master.sv
// two-wire bus master model, scl period 320 ns
// assumes the bench resolves sda with a pull-up into sdaBus
`timescale 1ns/10ps
module i2cs_bus_master (
   input wire logic clk,
   output logic scl,
   output logic sdaLow,
   input wire logic sdaBus
);
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // scl low lasts six clocks: the port answers about five clocks after a fall
   task automatic start();
      wait_clk(1);
      sdaLow <= 1'b0;
      wait_clk(5);
      scl <= 1'b1;
      wait_clk(4);
      sdaLow <= 1'b1;
      wait_clk(4);
      scl <= 1'b0;
   endtask
   task automatic stop();
      wait_clk(1);
      sdaLow <= 1'b1;
      wait_clk(5);
      scl <= 1'b1;
      wait_clk(4);
      sdaLow <= 1'b0;
      wait_clk(4);
   endtask
   // one bit of eight clocks: change sda only in scl low, sample at end of high
   task automatic xfer(input logic b, output logic r);
      wait_clk(1);
      sdaLow <= ~b;
      wait_clk(5);
      scl <= 1'b1;
      wait_clk(2);
      r = sdaBus;
      scl <= 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(1'b1, r);
         d[i] = r;
      end
      xfer(~ack, r);
   endtask
endmodule

// ===== verification/i2cs_testbench.sv
// self-checking bench for the two-wire control slave port
// assumes the master model paces the bus and drives it at clk_sys rising edges
`timescale 1ns/10ps
module testbench;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] sel = 3'h0;
   logic sdaOut, sdaOe, scl, sdaLow, ack;
   logic [127:0] regFile;
   logic [7:0] d;
   wire logic sdaBus = ~(sdaLow | sdaOe);
   int num_errors = 0;
   int total_checks = 0;
   initial forever #20 clk_sys = ~clk_sys;
   i2cs_control_port u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaBus),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_msb(sel[2]), .addr_select_mid(sel[1]),
      .addr_select_lsb(sel[0]), .regFile(regFile));
   i2cs_bus_master u_master (.clk(clk_sys), .scl(scl), .sdaLow(sdaLow), .sdaBus(sdaBus));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // write n bytes from index ix, e is the ack expected on every byte
   task automatic wr(input logic [2:0] a, input logic [7:0] ix, input logic [7:0] v,
                     input int n, input logic e);
      u_master.start();
      u_master.send({4'hd, a, 1'b0}, ack);
      chk("addr ack", e, ack);
      u_master.send(ix, ack);
      chk("index ack", e, ack);
      for (int k = 0; k < n; k++) begin
         u_master.send(v + k[7:0], ack);
         chk("data ack", e, ack);
      end
      u_master.stop();
   endtask
   task automatic s_read();
      logic [7:0] e[4] = '{8'ha0, 8'ha1, 8'ha2, 8'h00};
      u_master.start();
      u_master.send({4'hd, 3'h7, 1'b0}, ack);
      u_master.send(8'h0e, ack);
      u_master.start();
      u_master.send({4'hd, 3'h7, 1'b1}, ack);
      chk("read ack", 8'h01, ack);
      for (int k = 0; k < 4; k++) begin
         u_master.recv(k < 3, d);
         chk("read data", e[k], d);
      end
      u_master.stop();
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (int k = 0; k < 16; k++) chk("reset value", 8'h00, regFile[8*k+:8]);
      // every strap setting, one single-byte write each
      for (int s = 0; s < 8; s++) begin
         @(posedge clk_sys) sel <= s[2:0];
         repeat (4) @(posedge clk_sys);
         wr(s[2:0], 8'h01 + s[7:0], 8'h40 + s[7:0], 1, 1'b1);
         chk("single write", 8'h40 + s[7:0], regFile[8*s+:8]);
      end
      // run past the last register, the spill must not wrap
      wr(3'h7, 8'h0e, 8'ha0, 4, 1'b1);
      chk("multi write", 8'ha2, regFile[127:120]);
      chk("no wrap", 8'h40, regFile[7:0]);
      s_read();
      wr(3'h2, 8'h01, 8'hff, 2, 1'b0);
      chk("foreign address", 8'h40, regFile[7:0]);
      finish_test();
   end
endmodule
